// [hdl/hotplug_slot_control_status.sv]
// hot-plug slot control and status register for one downstream port
// assumes slot-side inputs are synchronous to clk and event inputs are
// one-cycle pulses; register port reads return data in the next cycle
//
// The plain strobed port was chosen for this implementation.
`default_nettype none

module hotplug_slot_control_status
   import hotplug_slot_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [addr_w-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // slot-side inputs
   input wire logic button_press,
   input wire logic power_fault,
   input wire logic latch_open,
   input wire logic card_present,
   input wire logic cmd_done,
   input wire logic link_active,
   input wire logic slot_implemented,
   // slot-side outputs
   output logic [1:0] attn_indicator,
   output logic [1:0] power_indicator,
   output logic slot_power_off,
   output logic electromechanical_lock_control,
   output logic attn_msg,
   output logic power_msg,
   // notification
   output logic hp_irq,
   output logic hp_wake
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [ctl_w-1:0] ctl;
      logic btn;
      logic pfd;
      logic mrlc;
      logic pdc;
      logic cc;
      logic dllsc;
      logic armed;
      logic mrl_prev;
      logic pres_prev;
      logic link_prev;
      logic attn_msg;
      logic pwr_msg;
      logic [31:0] rdata;
   } state_s;

   state_s q_ff;
   state_s nxt_q;

   function automatic logic hit(input logic [addr_w-1:0] a);
      hit = (a == slot_ctl_sts_off);
   endfunction : hit

   logic pres_eff;
   logic wr_hit;
   logic [5:0] evt_flags;
   logic [5:0] evt_ens;
   logic [5:0] evt_pend;

   // a slot-less port always reports a card so software never sees an empty slot
   assign pres_eff = slot_implemented ? card_present : 1'b1;
   assign wr_hit = reg_wr && hit(reg_addr);

   // ==========================================================
   // next state
   always_comb begin
      nxt_q = q_ff;
      nxt_q.attn_msg = 1'b0;
      nxt_q.pwr_msg = 1'b0;
      nxt_q.rdata = 32'h0;
      // first cycle after reset only samples, so idle-high inputs do not flag a change
      nxt_q.armed = 1'b1;
      nxt_q.mrl_prev = latch_open;
      nxt_q.pres_prev = pres_eff;
      nxt_q.link_prev = link_active;
      if (wr_hit) begin
         nxt_q.ctl = reg_wdata[ctl_w-1:0];
         nxt_q.attn_msg = 1'b1;
         nxt_q.pwr_msg = 1'b1;
         if (reg_wdata[sts_btn]) begin
            nxt_q.btn = 1'b0;
         end
         if (reg_wdata[sts_pfd]) begin
            nxt_q.pfd = 1'b0;
         end
         if (reg_wdata[sts_pdc]) begin
            nxt_q.pdc = 1'b0;
         end
         if (reg_wdata[sts_cc]) begin
            nxt_q.cc = 1'b0;
         end
         if (reg_wdata[sts_dllsc]) begin
            nxt_q.dllsc = 1'b0;
         end
      end
      // sets come after clears so a same-cycle event is kept
      if (button_press) begin
         nxt_q.btn = 1'b1;
      end
      if (power_fault) begin
         nxt_q.pfd = 1'b1;
      end
      if (q_ff.armed && latch_open != q_ff.mrl_prev) begin
         nxt_q.mrlc = 1'b1;
      end
      if (q_ff.armed && pres_eff != q_ff.pres_prev) begin
         nxt_q.pdc = 1'b1;
      end
      if (cmd_done) begin
         nxt_q.cc = 1'b1;
      end
      if (q_ff.armed && link_active != q_ff.link_prev) begin
         nxt_q.dllsc = 1'b1;
      end
      if (reg_rd && hit(reg_addr)) begin
         nxt_q.rdata[ctl_w-1:0] = q_ff.ctl;
         nxt_q.rdata[sts_btn] = q_ff.btn;
         nxt_q.rdata[sts_pfd] = q_ff.pfd;
         nxt_q.rdata[sts_mrlc] = q_ff.mrlc;
         nxt_q.rdata[sts_pdc] = q_ff.pdc;
         nxt_q.rdata[sts_cc] = q_ff.cc;
         nxt_q.rdata[sts_mrl_state] = latch_open;
         nxt_q.rdata[sts_pres_state] = pres_eff;
         nxt_q.rdata[sts_dllsc] = q_ff.dllsc;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_ff <= '0;
         q_ff.ctl <= ctl_rst;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ==========================================================
   // outputs
   assign evt_flags = {q_ff.dllsc, q_ff.cc, q_ff.pdc, q_ff.mrlc, q_ff.pfd, q_ff.btn};
   assign evt_ens = {q_ff.ctl[ctl_dll_en], q_ff.ctl[ctl_cc_en], q_ff.ctl[ctl_pdc_en],
      q_ff.ctl[ctl_mrl_en], q_ff.ctl[ctl_pfd_en], q_ff.ctl[ctl_btn_en]};
   assign evt_pend = evt_flags & evt_ens;
   assign hp_irq = q_ff.ctl[ctl_hp_ie] && (|evt_pend);
   // command completion only ever interrupts, it never wakes
   assign hp_wake = |{evt_pend[5], evt_pend[3:0]};

   assign reg_rdata = q_ff.rdata;
   // reserved 00 is stored and driven as written; the indicator treats it as don't-care
   assign attn_indicator = q_ff.ctl[ctl_attn_lo+1:ctl_attn_lo];
   assign power_indicator = q_ff.ctl[ctl_pwr_ind_lo+1:ctl_pwr_ind_lo];
   assign slot_power_off = q_ff.ctl[ctl_pwr_off];
   assign electromechanical_lock_control = q_ff.ctl[ctl_lock];
   assign attn_msg = q_ff.attn_msg;
   assign power_msg = q_ff.pwr_msg;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_ctl_write;
      reg_wr && hit(reg_addr);
   endsequence

   sequence s_msg_pulse;
      attn_msg && power_msg ##1 1'b1;
   endsequence

   a_msg_on_write: assert property (s_ctl_write |=> s_msg_pulse)
      else $error("indicator messages missing after write");

   a_msg_cause: assert property (attn_msg |-> $past(reg_wr) && $past(hit(reg_addr)))
      else $error("attention message without a write");

   a_power_cmd: assert property (s_ctl_write ##0 reg_wdata[ctl_pwr_off] |=> slot_power_off)
      else $error("power off request not applied");

   a_attn_field: assert property (s_ctl_write |=> attn_indicator == $past(reg_wdata[7:6]))
      else $error("attention field not stored");

   a_btn_set: assert property (button_press |=> q_ff.btn)
      else $error("button flag not set");

   a_btn_clear: assert property (s_ctl_write ##0 reg_wdata[sts_btn] && !button_press
      |=> !q_ff.btn)
      else $error("button flag not cleared");

   a_mrl_sticky: assert property (q_ff.mrlc |=> q_ff.mrlc)
      else $error("latch change flag lost");

   a_link_flag: assert property (q_ff.armed && link_active != q_ff.link_prev
      |=> q_ff.dllsc)
      else $error("link change not flagged");

   a_master_gate: assert property (!q_ff.ctl[ctl_hp_ie] |-> !hp_irq)
      else $error("interrupt without master enable");

   a_cc_irq: assert property (cmd_done && q_ff.ctl[ctl_cc_en] && q_ff.ctl[ctl_hp_ie]
      && !wr_hit |=> hp_irq)
      else $error("command completion did not interrupt");

   a_pres_forced: assert property (reg_rd && hit(reg_addr) && !slot_implemented
      |=> reg_rdata[sts_pres_state])
      else $error("presence not forced on slot-less port");

   // ==========================================================
   // read-back checks
   sequence s_ctl_read;
      reg_rd && hit(reg_addr);
   endsequence

   a_rd_attn_field: assert property (s_ctl_read |=> reg_rdata[7:6] == attn_indicator)
      else $error("attention field read back wrong");

   a_rd_pwr_field: assert property (s_ctl_read |=> reg_rdata[9:8] == power_indicator)
      else $error("power indicator field read back wrong");

   a_rd_power_bit: assert property (s_ctl_read
      |=> reg_rdata[ctl_pwr_off] == slot_power_off)
      else $error("power control bit read back wrong");

   a_rd_lock_bit: assert property (s_ctl_read
      |=> reg_rdata[ctl_lock] == electromechanical_lock_control)
      else $error("lock control bit read back wrong");

   a_rd_latch_live: assert property (s_ctl_read
      |=> reg_rdata[sts_mrl_state] == $past(latch_open))
      else $error("latch sensor state read back wrong");

   a_rd_card_live: assert property (s_ctl_read ##0 slot_implemented
      |=> reg_rdata[sts_pres_state] == $past(card_present))
      else $error("presence state read back wrong");

   a_rd_reserved: assert property (s_ctl_read
      |=> reg_rdata[15:13] == 3'h0 && !reg_rdata[23] && reg_rdata[31:25] == 7'h0)
      else $error("reserved bits read as nonzero");

   a_rd_idle_zero: assert property (!(reg_rd && hit(reg_addr)) |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");

   // ==========================================================
   // control and message checks
   a_pwr_field: assert property (s_ctl_write
      |=> power_indicator == $past(reg_wdata[9:8]))
      else $error("power indicator field not stored");

   a_power_on: assert property (s_ctl_write ##0 !reg_wdata[ctl_pwr_off]
      |=> !slot_power_off)
      else $error("power on request not applied");

   a_lock_field: assert property (s_ctl_write
      |=> electromechanical_lock_control == $past(reg_wdata[ctl_lock]))
      else $error("lock control bit not stored");

   a_ctl_hold: assert property (!(reg_wr && hit(reg_addr)) |=> $stable(attn_indicator)
      && $stable(power_indicator) && $stable(slot_power_off))
      else $error("control outputs moved without a write");

   a_msg_quiet: assert property (!(reg_wr && hit(reg_addr))
      |=> !attn_msg && !power_msg)
      else $error("indicator message without a write");

   // ==========================================================
   // status flag checks
   sequence s_latch_change;
      q_ff.armed && latch_open != q_ff.mrl_prev;
   endsequence

   sequence s_pres_change;
      q_ff.armed && pres_eff != q_ff.pres_prev;
   endsequence

   a_btn_keep: assert property (q_ff.btn && !(wr_hit && reg_wdata[sts_btn])
      |=> q_ff.btn)
      else $error("button flag lost without a clear");

   a_btn_set_wins: assert property (s_ctl_write ##0 reg_wdata[sts_btn] && button_press
      |=> q_ff.btn)
      else $error("clear beat a same-cycle button press");

   a_pfd_set: assert property (power_fault |=> q_ff.pfd)
      else $error("power fault flag not set");

   a_pfd_clear: assert property (s_ctl_write ##0 reg_wdata[sts_pfd] && !power_fault
      |=> !q_ff.pfd)
      else $error("power fault flag not cleared");

   a_mrl_set: assert property (s_latch_change |=> q_ff.mrlc)
      else $error("latch sensor change not flagged");

   a_pdc_set: assert property (s_pres_change |=> q_ff.pdc)
      else $error("presence change not flagged");

   a_pdc_clear: assert property (s_ctl_write ##0 reg_wdata[sts_pdc]
      && !(q_ff.armed && pres_eff != q_ff.pres_prev) |=> !q_ff.pdc)
      else $error("presence change flag not cleared");

   a_cc_set: assert property (cmd_done |=> q_ff.cc)
      else $error("command completed flag not set");

   a_cc_clear: assert property (s_ctl_write ##0 reg_wdata[sts_cc] && !cmd_done
      |=> !q_ff.cc)
      else $error("command completed flag not cleared");

   a_dll_clear: assert property (s_ctl_write ##0 reg_wdata[sts_dllsc]
      && !(q_ff.armed && link_active != q_ff.link_prev) |=> !q_ff.dllsc)
      else $error("link change flag not cleared");

   // ==========================================================
   // notification checks
   a_btn_irq: assert property (q_ff.btn && q_ff.ctl[ctl_btn_en] && q_ff.ctl[ctl_hp_ie]
      |-> hp_irq)
      else $error("enabled button press did not interrupt");

   a_pfd_irq: assert property (q_ff.pfd && q_ff.ctl[ctl_pfd_en] && q_ff.ctl[ctl_hp_ie]
      |-> hp_irq)
      else $error("enabled power fault did not interrupt");

   a_mrl_irq: assert property (q_ff.mrlc && q_ff.ctl[ctl_mrl_en] && q_ff.ctl[ctl_hp_ie]
      |-> hp_irq)
      else $error("enabled latch change did not interrupt");

   a_pdc_irq: assert property (q_ff.pdc && q_ff.ctl[ctl_pdc_en] && q_ff.ctl[ctl_hp_ie]
      |-> hp_irq)
      else $error("enabled presence change did not interrupt");

   a_dll_irq: assert property (q_ff.dllsc && q_ff.ctl[ctl_dll_en] && q_ff.ctl[ctl_hp_ie]
      |-> hp_irq)
      else $error("enabled link change did not interrupt");

   a_btn_wake: assert property (q_ff.btn && q_ff.ctl[ctl_btn_en] |-> hp_wake)
      else $error("enabled button press did not wake");

   // completion alone must never wake the port
   a_cc_no_wake: assert property (!q_ff.btn && !q_ff.pfd && !q_ff.mrlc && !q_ff.pdc
      && !q_ff.dllsc |-> !hp_wake)
      else $error("wake without a wake-capable event");

   a_irq_quiet: assert property (q_ff.ctl[ctl_cc_en:ctl_btn_en] == 5'h0
      && !q_ff.ctl[ctl_dll_en] |-> !hp_irq && !hp_wake)
      else $error("notification with every event disabled");

   // ==========================================================
   // reset checks stay live while rst is high
   a_reset_ctl: assert property (disable iff (1'b0) rst |=> attn_indicator == attn_rst
      && power_indicator == pwr_ind_rst && !slot_power_off)
      else $error("control outputs not at reset values");

   a_reset_flags: assert property (disable iff (1'b0) rst |=> !q_ff.btn && !q_ff.pfd
      && !q_ff.mrlc && !q_ff.pdc && !q_ff.cc && !q_ff.dllsc
      && reg_rdata == 32'h0 && !attn_msg)
      else $error("flags or read data not cleared by reset");

endmodule : hotplug_slot_control_status

`default_nettype wire

// [hdl/hotplug_slot_pkg.sv]
// constants for the hot-plug slot control and status register logic
// assumes a single core clock and a synchronous active-high port reset
`default_nettype none

package hotplug_slot_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] slot_ctl_sts_off = 8'hd8;
   localparam int addr_w = 8;
   localparam int ctl_w = 13;

   // ==========================================================
   // control field positions (low half of the word)
   localparam int ctl_btn_en = 0;
   localparam int ctl_pfd_en = 1;
   localparam int ctl_mrl_en = 2;
   localparam int ctl_pdc_en = 3;
   localparam int ctl_cc_en = 4;
   localparam int ctl_hp_ie = 5;
   localparam int ctl_attn_lo = 6;
   localparam int ctl_pwr_ind_lo = 8;
   localparam int ctl_pwr_off = 10;
   localparam int ctl_lock = 11;
   localparam int ctl_dll_en = 12;

   // ==========================================================
   // status field positions (high half of the word)
   localparam int sts_btn = 16;
   localparam int sts_pfd = 17;
   localparam int sts_mrlc = 18;
   localparam int sts_pdc = 19;
   localparam int sts_cc = 20;
   localparam int sts_mrl_state = 21;
   localparam int sts_pres_state = 22;
   localparam int sts_dllsc = 24;

   // ==========================================================
   // indicator encodings and reset values
   localparam logic [1:0] ind_rsvd = 2'h0;
   localparam logic [1:0] ind_on = 2'h1;
   localparam logic [1:0] ind_blink = 2'h2;
   localparam logic [1:0] ind_off = 2'h3;
   localparam logic [1:0] attn_rst = ind_off;
   localparam logic [1:0] pwr_ind_rst = ind_on;
   localparam logic [12:0] ctl_rst = 13'h1c0;

endpackage : hotplug_slot_pkg

`default_nettype wire

// [verif/hotplug_slot_control_status_bench.sv]
// bench for the hot-plug slot register: register port tasks plus slot model
// assumes one clock, synchronous reset and single-cycle register strobes
`default_nettype none

module hotplug_slot_control_status_bench;
   import hotplug_slot_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst, reg_wr, reg_rd, hp_irq, hp_wake;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic button_press, power_fault, latch_open, card_present;
   logic cmd_done, link_active, slot_implemented;
   logic [1:0] attn_indicator, power_indicator;
   logic slot_power_off, lock_out, attn_msg, power_msg;
   int miscompares = 0;
   int total_checks = 0;
   int sb[6] = '{sts_btn, sts_pfd, sts_mrlc, sts_pdc, sts_cc, sts_dllsc};
   int eb[6] = '{ctl_btn_en, ctl_pfd_en, ctl_mrl_en, ctl_pdc_en, ctl_cc_en, ctl_dll_en};

   hotplug_slot_control_status uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .button_press(button_press), .power_fault(power_fault), .latch_open(latch_open),
      .card_present(card_present), .cmd_done(cmd_done), .link_active(link_active),
      .slot_implemented(slot_implemented), .attn_indicator(attn_indicator),
      .power_indicator(power_indicator), .slot_power_off(slot_power_off),
      .electromechanical_lock_control(lock_out), .attn_msg(attn_msg),
      .power_msg(power_msg), .hp_irq(hp_irq), .hp_wake(hp_wake));

   slot_model slot (.clk(clk), .button_press(button_press), .power_fault(power_fault),
      .latch_open(latch_open), .card_present(card_present), .cmd_done(cmd_done),
      .link_active(link_active), .slot_implemented(slot_implemented));

   initial begin
      clk = 1'b0;
      forever #20 clk = !clk;
   end

   // ==========================================================
   // register port and comparisons
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk1(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask : chk1

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // ==========================================================
   // tests
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(slot_ctl_sts_off, d);
      chk("reset word", 32'h1c0, d);
      chk("reset pins", 32'hd, {28'h0, attn_indicator, power_indicator});
      @(posedge clk);
      #1 chk("rdata drop", 32'h0, reg_rdata);
      wr(slot_ctl_sts_off, 32'h163f);
      chk("ind pins", 32'h2, {28'h0, attn_indicator, power_indicator});
      chk1("power off", 1'b1, slot_power_off);
      chk("msgs", 32'h3, {30'h0, attn_msg, power_msg});
      wr(8'h10, 32'h0);
      rd(slot_ctl_sts_off, d);
      chk("unmapped wr", 32'h163f, d);
      rd(8'h10, d);
      chk("unmapped rd", 32'h0, d);
      wr(slot_ctl_sts_off, 32'h880);
      chk("blink pins", 32'h8, {28'h0, attn_indicator, power_indicator});
      chk1("power on", 1'b0, slot_power_off);
      chk1("lock", 1'b1, lock_out);
      for (int k = 0; k < 6; k++) begin
         wr(slot_ctl_sts_off, 32'h20);
         slot.ev(k);
         rd(slot_ctl_sts_off, d);
         chk1("flag set", 1'b1, d[sb[k]]);
         if (k == 2) chk1("latch", 1'b1, d[sts_mrl_state]);
         if (k == 3) chk1("present", 1'b1, d[sts_pres_state]);
         chk1("irq no enable", 1'b0, hp_irq);
         wr(slot_ctl_sts_off, 32'h1 << eb[k]);
         chk1("irq no master", 1'b0, hp_irq);
         chk1("wake", k != 4, hp_wake);
         wr(slot_ctl_sts_off, (32'h1 << eb[k]) | 32'h20);
         chk1("irq", 1'b1, hp_irq);
         wr(slot_ctl_sts_off, (32'h1 << sb[k]) | (32'h1 << eb[k]) | 32'h20);
         rd(slot_ctl_sts_off, d);
         chk1("flag clear", k == 2, d[sb[k]]);
         chk1("irq cleared", k == 2, hp_irq);
      end
      slot.ev(3);
      wr(slot_ctl_sts_off, 32'h1 << sts_pdc);
      rd(slot_ctl_sts_off, d);
      chk1("empty", 1'b0, d[sts_pres_state]);
      chk1("pdc cleared", 1'b0, d[sts_pdc]);
      slot.ev(6);
      rd(slot_ctl_sts_off, d);
      chk1("presence forced", 1'b1, d[sts_pres_state]);
      chk1("forced change", 1'b1, d[sts_pdc]);
      // second reset in mid-run: latch stays open, presence stays forced
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(slot_ctl_sts_off, d);
      chk("second reset", 32'h6001c0, d);
      end_sim;
   end

   // the tests take about 150 cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_sim;
   end
endmodule : hotplug_slot_control_status_bench

`default_nettype wire

// [verif/slot_model.sv]
// slot-side model: attention button, sensors, power controller and link
// assumes the bench calls ev between clock edges, one call at a time
`default_nettype none

module slot_model (
   // clock
   input wire logic clk,
   // slot events and levels
   output logic button_press,
   output logic power_fault,
   output logic latch_open,
   output logic card_present,
   output logic cmd_done,
   output logic link_active,
   output logic slot_implemented
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {button_press, power_fault, latch_open, card_present} = 4'h0;
      {cmd_done, link_active, slot_implemented} = 3'h1;
   end

   // ==========================================================
   // events are one-cycle pulses; latch, presence and link levels toggle, slot_implemented clears, and all then stay
   task automatic ev(input int k);
      @(posedge clk);
      case (k)
         0: button_press <= 1'b1;
         1: power_fault <= 1'b1;
         2: latch_open <= !latch_open;
         3: card_present <= !card_present;
         4: cmd_done <= 1'b1;
         5: link_active <= !link_active;
         default: slot_implemented <= 1'b0;
      endcase
      @(posedge clk);
      {button_press, power_fault, cmd_done} <= 3'h0;
      // level changes may need an extra edge to be seen
      repeat (2) @(posedge clk);
   endtask : ev
endmodule : slot_model

`default_nettype wire
